// >>> cgw_gateway.sv
// message memory with normal gateway engine and apb access
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "cgw_cfg.svh"
module cgw_gateway (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // matched frames from node controllers
   input wire logic i_rx_valid,
   output logic o_rx_ready,
   input wire cgw_pkg::cgw_evt_t i_rx_evt,
   // per object state to node controllers
   output logic [31:0] o_obj_node,
   output logic [31:0] o_tx_pending,
   output logic [31:0] o_tx_remote
);
   import cgw_pkg::*;
   // ***********************************************
   // object storage
   // ***********************************************
   logic [31:0] cfg [`CGW_NOBJ], next_cfg [`CGW_NOBJ];
   logic [28:0] id [`CGW_NOBJ], next_id [`CGW_NOBJ];
   logic [63:0] data [`CGW_NOBJ], next_data [`CGW_NOBJ];
   logic [31:0] fg [`CGW_NOBJ], next_fg [`CGW_NOBJ];
   logic [5:0] ctl [`CGW_NOBJ], next_ctl [`CGW_NOBJ];
   cgw_state_t st, next_st;
   cgw_evt_t evt, next_evt, f_evt;
   logic f_valid, f_ready;
   logic [31:0] next_prdata;
   logic rd_err, next_rd_err;
   logic wr_en, setup, apply, gw_copy, fwd;
   logic [4:0] o_idx, gw_dst, sel_obj;
   logic [5:0] src_hit;
   logic [4:0] reg_sel;
   logic [31:0] pend_c, rmt_c, node_c;

   function automatic logic [4:0] wrap_ptr(input logic [4:0] p,
                                           input logic [4:0] fs);
      wrap_ptr = (p & ~fs) | ((p + 5'h01) & fs);
   endfunction : wrap_ptr

   function automatic logic [5:0] find_src(input logic [4:0] d);
      logic [5:0] r;
      r = 6'h00;
      for (int i = `CGW_NOBJ - 1; i >= 0; i--) begin
         if (fg[i][`CGW_FG_MMC] == `CGW_MMC_GW && !cfg[i][`CGW_CFG_DIR]
             && fg[i][`CGW_FG_PTR] == d) begin
            r = {1'b1, 5'(i)};
         end
      end
      find_src = r;
   endfunction : find_src

   function automatic logic reg_ok(input logic [31:0] a);
      reg_ok = (a[31:10] == 22'h0) && (a[4:0] <= `CGW_REG_CTRL)
               && (a[1:0] == 2'h0);
   endfunction : reg_ok

   // ***********************************************
   // event buffer
   // ***********************************************
   cgw_fifo #(
      .WIDTH($bits(cgw_evt_t)),
      .DEPTH(`CGW_FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(i_rx_valid),
      .o_in_ready(o_rx_ready),
      .i_in_data(i_rx_evt),
      .o_out_valid(f_valid),
      .i_out_ready(f_ready),
      .o_out_data(f_evt)
   );

   // ***********************************************
   // apb decode
   // ***********************************************
   assign reg_sel = i_paddr[4:0];
   assign sel_obj = i_paddr[9:5];
   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && i_pwrite && reg_ok(i_paddr);
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && rd_err;

   always_comb begin
      next_prdata = o_prdata;
      next_rd_err = rd_err;
      if (setup) begin
         next_rd_err = !reg_ok(i_paddr);
         next_prdata = 32'h0;
         unique case (reg_sel)
            `CGW_REG_CFG: next_prdata = cfg[sel_obj];
            `CGW_REG_ID: next_prdata = {3'h0, id[sel_obj]};
            `CGW_REG_DLO: next_prdata = data[sel_obj][31:0];
            `CGW_REG_DHI: next_prdata = data[sel_obj][63:32];
            `CGW_REG_FGCR: next_prdata = fg[sel_obj];
            `CGW_REG_CTRL: next_prdata = {26'h0, ctl[sel_obj]};
            default: next_prdata = 32'h0;
         endcase
         if (!reg_ok(i_paddr)) begin
            next_prdata = 32'h0;
         end
      end
   end

   // ***********************************************
   // gateway engine
   // ***********************************************
   assign o_idx = evt.obj;
   assign apply = (st == ST_APPLY) && !i_psel;
   assign f_ready = (st == ST_FETCH);
   assign gw_copy = apply && !evt.remote
      && fg[o_idx][`CGW_FG_MMC] == `CGW_MMC_GW
      && !cfg[o_idx][`CGW_CFG_DIR];
   assign gw_dst = fg[o_idx][`CGW_FG_PTR];
   // search reads the cfg and fg words of every object, so it must follow each of them
   always_comb begin
      src_hit = find_src(o_idx);
   end
   assign fwd = fg[o_idx][`CGW_FG_MMC] == `CGW_MMC_GW
      && fg[o_idx][`CGW_FG_REMOTE_FORWARDING_BIT] && src_hit[5];

   always_comb begin
      next_st = st;
      next_evt = evt;
      unique case (st)
         ST_FETCH: begin
            if (f_valid) begin
               next_evt = f_evt;
               next_st = ST_APPLY;
            end
         end
         ST_APPLY: begin
            if (apply) begin
               next_st = ST_FETCH;
            end
         end
      endcase
   end

   always_comb begin
      next_cfg = cfg;
      next_id = id;
      next_data = data;
      next_fg = fg;
      next_ctl = ctl;
      if (wr_en) begin
         unique case (reg_sel)
            `CGW_REG_CFG: next_cfg[sel_obj] = i_pwdata;
            `CGW_REG_ID: next_id[sel_obj] = i_pwdata[28:0];
            `CGW_REG_DLO: next_data[sel_obj][31:0] = i_pwdata;
            `CGW_REG_DHI: next_data[sel_obj][63:32] = i_pwdata;
            `CGW_REG_FGCR: next_fg[sel_obj] = i_pwdata;
            `CGW_REG_CTRL: next_ctl[sel_obj] = i_pwdata[5:0];
            default: next_ctl[sel_obj] = ctl[sel_obj];
         endcase
      end
      if (apply && !evt.remote) begin
         next_data[o_idx] = evt.data;
         next_cfg[o_idx][`CGW_CFG_DLC] = evt.dlc;
         if (gw_copy) begin
            next_data[gw_dst] = evt.data;
            if (fg[o_idx][`CGW_FG_IDC]) begin
               next_id[gw_dst] = evt.id;
            end
            if (fg[o_idx][`CGW_FG_LENGTH_COPY_BIT]) begin
               next_cfg[gw_dst][`CGW_CFG_DLC] = evt.dlc;
            end
            if (fg[o_idx][`CGW_FG_TRANSMIT_ON_ARRIVAL_BIT]) begin
               next_ctl[gw_dst][`CGW_CT_TRANSMIT_REQUEST_FIELD] = `CGW_FLAG_SET;
            end
            if (fg[gw_dst][`CGW_FG_MMC] == `CGW_MMC_STD) begin
               next_fg[gw_dst][`CGW_FG_PTR] = gw_dst;
            end
            if (fg[o_idx][`CGW_FG_BUFFER_SIZE_FIELD] != 5'h00) begin
               next_fg[o_idx][`CGW_FG_PTR] = wrap_ptr(gw_dst,
                  fg[o_idx][`CGW_FG_BUFFER_SIZE_FIELD]);
            end
         end
      end else if (apply) begin
         if (fwd) begin
            next_ctl[src_hit[4:0]][`CGW_CT_TRANSMIT_REQUEST_FIELD] = `CGW_FLAG_SET;
         end else begin
            next_ctl[o_idx][`CGW_CT_TRANSMIT_REQUEST_FIELD] = `CGW_FLAG_SET;
            next_ctl[o_idx][`CGW_CT_REMOTE_PENDING_FIELD] = `CGW_FLAG_SET;
         end
      end
   end

   // ***********************************************
   // per object outputs
   // ***********************************************
   for (genvar g = 0; g < `CGW_NOBJ; g++) begin : g_obj
      assign node_c[g] = cfg[g][`CGW_CFG_NODE];
      assign pend_c[g] = ctl[g][`CGW_CT_TRANSMIT_REQUEST_FIELD] == `CGW_FLAG_SET
         && ctl[g][`CGW_CT_CPU_UPDATE_FIELD] == `CGW_FLAG_RST;
      assign rmt_c[g] = fg[g][`CGW_FG_MMC] == `CGW_MMC_GW
         && !cfg[g][`CGW_CFG_DIR];
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= ST_FETCH;
         evt <= '0;
         o_prdata <= 32'h0;
         rd_err <= 1'b0;
         o_obj_node <= 32'h0;
         o_tx_pending <= 32'h0;
         o_tx_remote <= 32'h0;
         for (int i = 0; i < `CGW_NOBJ; i++) begin
            cfg[i] <= 32'h0;
            id[i] <= 29'h0;
            data[i] <= 64'h0;
            fg[i] <= 32'h0;
            ctl[i] <= {`CGW_FLAG_RST, `CGW_FLAG_RST, `CGW_FLAG_RST};
         end
      end else begin
         st <= next_st;
         evt <= next_evt;
         o_prdata <= next_prdata;
         rd_err <= next_rd_err;
         o_obj_node <= node_c;
         o_tx_pending <= pend_c;
         o_tx_remote <= rmt_c;
         cfg <= next_cfg;
         id <= next_id;
         data <= next_data;
         fg <= next_fg;
         ctl <= next_ctl;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   a_ptr_cpu_keep: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_en && reg_sel != `CGW_REG_FGCR && !apply)
      |=> fg[$past(sel_obj)][`CGW_FG_PTR]
          == $past(fg[sel_obj][`CGW_FG_PTR]))
      else $error("cpu access moved object pointer");
   a_node_out: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      ##1 o_obj_node == $past(node_c))
      else $error("node output wrong");
   a_copy_data: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      gw_copy |=> data[$past(gw_dst)] == $past(evt.data))
      else $error("gateway data not copied");
   a_id_copy: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      gw_copy |=> id[$past(gw_dst)] == ($past(fg[o_idx][`CGW_FG_IDC])
         ? $past(evt.id) : $past(id[gw_dst])))
      else $error("identifier copy wrong");
   a_dlc_copy: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (gw_copy && fg[o_idx][`CGW_FG_LENGTH_COPY_BIT])
      |=> cfg[$past(gw_dst)][`CGW_CFG_DLC] == $past(evt.dlc))
      else $error("length code not copied");
   a_transmit_request_field_arrival: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (gw_copy && fg[o_idx][`CGW_FG_TRANSMIT_ON_ARRIVAL_BIT])
      |=> ctl[$past(gw_dst)][`CGW_CT_TRANSMIT_REQUEST_FIELD] == `CGW_FLAG_SET)
      else $error("transmit request not set");
   a_ptr_self: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (gw_copy && fg[gw_dst][`CGW_FG_MMC] == `CGW_MMC_STD)
      |=> fg[$past(gw_dst)][`CGW_FG_PTR] == $past(gw_dst))
      else $error("destination pointer not own number");
   a_remote_local: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (apply && evt.remote && fg[o_idx][`CGW_FG_MMC] == `CGW_MMC_STD)
      |=> ctl[$past(o_idx)][3:0] == {`CGW_FLAG_SET, `CGW_FLAG_SET})
      else $error("remote frame not answered locally");
   a_fifo_remote: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (apply && evt.remote && (fg[o_idx][`CGW_FG_MMC] == `CGW_MMC_FBASE
         || fg[o_idx][`CGW_FG_MMC] == `CGW_MMC_FSLAVE))
      |=> ctl[$past(o_idx)][3:0] == {`CGW_FLAG_SET, `CGW_FLAG_SET})
      else $error("fifo element did not answer remote frame");
   a_fifo_wrap: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (gw_copy && fg[o_idx][`CGW_FG_BUFFER_SIZE_FIELD] != 5'h00)
      |=> fg[$past(o_idx)][`CGW_FG_PTR]
          == wrap_ptr($past(gw_dst), $past(fg[o_idx][`CGW_FG_BUFFER_SIZE_FIELD])))
      else $error("source pointer did not wrap");
   a_src_remote: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (apply && evt.remote && fwd)
      |=> ##1 o_tx_remote[$past(src_hit[4:0], 2)])
      else $error("source object would send data frame");
   a_no_split: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_psel |-> !apply)
      else $error("copy during cpu access");
endmodule : cgw_gateway

// >>> cgw_cfg.svh
// constants of the can gateway message memory
`ifndef CGW_CFG_SVH
`define CGW_CFG_SVH
// ***********************************************
// address map, one 32 byte slot per object
// ***********************************************
`define CGW_NOBJ 32
`define CGW_REG_CFG 5'h00
`define CGW_REG_ID 5'h04
`define CGW_REG_DLO 5'h08
`define CGW_REG_DHI 5'h0C
`define CGW_REG_FGCR 5'h10
`define CGW_REG_CTRL 5'h14
// ***********************************************
// field positions
// ***********************************************
`define CGW_CFG_NODE 0
`define CGW_CFG_DIR 1
`define CGW_CFG_DLC 7:4
`define CGW_FG_MMC 2:0
`define CGW_FG_PTR 12:8
`define CGW_FG_BUFFER_SIZE_FIELD 20:16
`define CGW_FG_IDC 24
`define CGW_FG_LENGTH_COPY_BIT 25
`define CGW_FG_TRANSMIT_ON_ARRIVAL_BIT 26
`define CGW_FG_REMOTE_FORWARDING_BIT 27
`define CGW_CT_TRANSMIT_REQUEST_FIELD 1:0
`define CGW_CT_REMOTE_PENDING_FIELD 3:2
`define CGW_CT_CPU_UPDATE_FIELD 5:4
// ***********************************************
// codes and reset values
// ***********************************************
`define CGW_MMC_STD 3'h0
`define CGW_MMC_GW 3'h4
`define CGW_MMC_FBASE 3'h2
`define CGW_MMC_FSLAVE 3'h3
`define CGW_FLAG_SET 2'h2
`define CGW_FLAG_RST 2'h1
`define CGW_FIFO_DEPTH 8
`endif

// >>> cgw_pkg.sv
// types of the can gateway message memory
package cgw_pkg;
   typedef struct packed {
      logic remote;
      logic [4:0] obj;
      logic [28:0] id;
      logic [3:0] dlc;
      logic [63:0] data;
   } cgw_evt_t;
   typedef enum logic [1:0] {
      ST_FETCH = 2'b01,
      ST_APPLY = 2'b10
   } cgw_state_t;
endpackage : cgw_pkg

// >>> cgw_fifo.sv
// small first in first out buffer for frame events
`timescale 1ns/1ps
module cgw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;
   assign o_in_ready = (cnt != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt != '0);
   assign o_out_data = mem[rp];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   always_comb begin
      next_wp = push ? wp + 1'b1 : wp;
      next_rp = pop ? rp + 1'b1 : rp;
      next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wp] <= i_in_data;
      end
   end
endmodule : cgw_fifo

// >>> cgw_node_model.sv
// node controller side model offering matched frames to the gateway
`timescale 1ns/1ps
module cgw_node_model (
   // clock
   input wire logic i_core_clk,
   // frame offer
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   output cgw_pkg::cgw_evt_t o_rx_evt
);
   import cgw_pkg::*;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_evt = '0;
   end
   // offer one frame after some idle edges, hold it until taken
   task automatic send(input cgw_evt_t e, input int stall);
      repeat (1 + stall) @(posedge i_core_clk);
      o_rx_valid <= 1'b1;
      o_rx_evt <= e;
      do @(posedge i_core_clk); while (i_rx_ready !== 1'b1);
      o_rx_valid <= 1'b0;
      // released lines never keep the last frame
      o_rx_evt <= ~e;
   endtask : send
endmodule : cgw_node_model

// >>> cgw_gateway_test.sv
// self-checking bench of the can gateway message memory
`timescale 1ns/1ps
`include "cgw_cfg.svh"
module cgw_gateway_test;
   import cgw_pkg::*;
   localparam int S = 3;
   localparam int D = 5;
   localparam int B = 8;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [31:0] padr = 32'h0;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, node_v, pend_v, rem_v;
   logic prdy, perr, rxv, rxr;
   cgw_evt_t evt;
   logic [31:0] seed = 32'd89193;
   int fails = 0;
   int tests_run = 0;
   always #5 i_core_clk = ~i_core_clk;
   cgw_gateway dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
      .i_rx_valid(rxv), .o_rx_ready(rxr), .i_rx_evt(evt),
      .o_obj_node(node_v), .o_tx_pending(pend_v), .o_tx_remote(rem_v));
   cgw_node_model node_u (.i_core_clk(i_core_clk), .o_rx_valid(rxv),
      .i_rx_ready(rxr), .o_rx_evt(evt));
   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic logic [31:0] adr(input int o, input logic [4:0] f);
      return {22'h0, 5'(o), f};
   endfunction : adr
   function automatic logic [31:0] fg(input logic i, l, g, s,
      input logic [4:0] fs, input int p, input logic [2:0] mm);
      return {4'h0, s, g, l, i, 3'h0, fs, 3'h0, 5'(p), 5'h0, mm};
   endfunction : fg
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   task automatic apb(input logic w, input logic [31:0] a, d,
      output logic [31:0] r, output logic e);
      @(posedge i_core_clk);
      {psel, pen, pwr, padr, pwd} <= {2'b10, w, a, d};
      @(posedge i_core_clk);
      pen <= 1'b1;
      do @(posedge i_core_clk); while (prdy !== 1'b1);
      r = prd;
      e = perr;
      {psel, pen} <= 2'b00;
   endtask : apb
   task automatic wr(input int o, input logic [4:0] f, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, adr(o, f), d, r, e);
   endtask : wr
   task automatic rd(input int o, input logic [4:0] f, output logic [31:0] r);
      logic e;
      apb(1'b0, adr(o, f), 32'h0, r, e);
   endtask : rd
   task automatic ev(input logic rm, input int o, output cgw_evt_t e);
      e.remote = rm;
      e.obj = 5'(o);
      e.id = 29'(rnd());
      e.dlc = 4'(rnd());
      e.data = {rnd(), rnd()};
      node_u.send(e, int'(rnd() & 32'h3));
      repeat (8) @(posedge i_core_clk);
   endtask : ev
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      logic [31:0] r, lo;
      logic c, er;
      cgw_evt_t e;
      int p;
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      rd(0, `CGW_REG_CTRL, r);
      chk(r, 32'h15);
      rd(0, `CGW_REG_FGCR, r);
      chk(r, 32'h0);
      for (int k = 0; k < 4; k++) begin
         c = k[0];
         wr(S, `CGW_REG_CFG, 32'h0);
         wr(D, `CGW_REG_CFG, 32'h3);
         wr(S, `CGW_REG_FGCR, fg(c, c, c, 1'b0, 5'h0, D, `CGW_MMC_GW));
         wr(D, `CGW_REG_FGCR, 32'h0);
         wr(D, `CGW_REG_ID, 32'h5A5);
         wr(D, `CGW_REG_CTRL, 32'h15);
         ev(1'b0, S, e);
         rd(D, `CGW_REG_DLO, r);
         chk(r, e.data[31:0]);
         rd(D, `CGW_REG_DHI, r);
         chk(r, e.data[63:32]);
         rd(D, `CGW_REG_ID, r);
         chk(r, c ? 32'(e.id) : 32'h5A5);
         rd(D, `CGW_REG_CFG, r);
         chk(r, c ? {24'h0, e.dlc, 4'h3} : 32'h3);
         rd(D, `CGW_REG_CTRL, r);
         chk(r, c ? 32'h16 : 32'h15);
         chk(32'(pend_v[D]), 32'(c));
         rd(D, `CGW_REG_FGCR, r);
         chk(r, fg(0, 0, 0, 0, 5'h0, D, `CGW_MMC_STD));
         rd(S, `CGW_REG_FGCR, r);
         chk(r, fg(c, c, c, 1'b0, 5'h0, D, `CGW_MMC_GW));
         chk(node_v, 32'h1 << D);
         chk(rem_v, 32'h1 << S);
      end
      wr(S, `CGW_REG_FGCR, fg(1, 1, 1, 0, 5'h0, D, `CGW_MMC_STD));
      rd(D, `CGW_REG_DLO, lo);
      ev(1'b0, S, e);
      rd(D, `CGW_REG_DLO, r);
      chk(r, lo);
      chk(rem_v, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(S, `CGW_REG_FGCR, fg(0, 0, 0, 0, 5'h0, D, `CGW_MMC_GW));
         wr(D, `CGW_REG_FGCR, fg(0, 0, 0, m != 1, 5'h0, D,
            m == 0 ? `CGW_MMC_STD : `CGW_MMC_GW));
         wr(S, `CGW_REG_CTRL, 32'h15);
         wr(D, `CGW_REG_CTRL, 32'h15);
         ev(1'b1, D, e);
         rd(D, `CGW_REG_CTRL, r);
         chk(r, m == 2 ? 32'h15 : 32'h1A);
         rd(S, `CGW_REG_CTRL, r);
         chk(r, m == 2 ? 32'h16 : 32'h15);
         chk(32'(pend_v[S]), 32'(m == 2));
      end
      wr(S, `CGW_REG_FGCR, fg(0, 0, 0, 0, 5'h1, B, `CGW_MMC_GW));
      for (int k = 0; k < 2; k++) begin
         wr(B + k, `CGW_REG_CFG, 32'h3);
         wr(B + k, `CGW_REG_FGCR, fg(0, 0, 0, 0, 5'h1, B, 3'(2 + k)));
      end
      p = B;
      for (int k = 0; k < 3; k++) begin
         ev(1'b0, S, e);
         rd(p, `CGW_REG_DLO, r);
         chk(r, e.data[31:0]);
         p = (p & ~1) | ((p + 1) & 1);
         rd(S, `CGW_REG_FGCR, r);
         chk(r, fg(0, 0, 0, 0, 5'h1, p, `CGW_MMC_GW));
      end
      wr(B + 1, `CGW_REG_CTRL, 32'h15);
      wr(S, `CGW_REG_CTRL, 32'h15);
      ev(1'b1, B + 1, e);
      rd(B + 1, `CGW_REG_CTRL, r);
      chk(r, 32'h1A);
      rd(S, `CGW_REG_CTRL, r);
      chk(r, 32'h15);
      for (int k = 0; k < 2; k++) begin
         apb(1'b0, k == 0 ? adr(0, 5'h18) : 32'h400 | adr(D, `CGW_REG_CFG),
            32'h0, r, er);
         chk(r, 32'h0);
         chk(32'(er), 32'h1);
      end
      // back to back reads park the engine while the buffer fills
      @(posedge i_core_clk);
      e = '0;
      e.obj = 5'd20;
      {psel, pwr, padr} <= {2'b10, adr(20, `CGW_REG_DLO)};
      fork
         for (int i = 0; i < 9; i++) begin
            e.data = {rnd(), rnd()};
            node_u.send(e, 0);
         end
         repeat (39) begin
            @(posedge i_core_clk);
            pen <= ~pen;
         end
      join
      chk(32'(rxr), 32'h0);
      chk(prd, 32'h0);
      @(posedge i_core_clk);
      {psel, pen} <= 2'b00;
      repeat (30) @(posedge i_core_clk);
      chk(32'(rxr), 32'h1);
      rd(20, `CGW_REG_DLO, r);
      chk(r, e.data[31:0]);
      wrap_up();
   end
   initial begin
      #300000;
      fails++;
      wrap_up();
   end
endmodule : cgw_gateway_test
